/* verilog/fdcr_cfg.svh */
// Offsets, field positions, reset values and timing counts
// for the drive control register bank.
// Assumes a 10-bit host I/O address and a 40 MHz clock.
`ifndef FDCR_CFG_SVH
`define FDCR_CFG_SVH

`define FDCR_ADDR_W 10
`define FDCR_OFS_STATUS2 10'h3F1
`define FDCR_OFS_OUTCTL 10'h3F2
`define FDCR_OFS_TAPE 10'h3F3
`define FDCR_OFS_DIGIN 10'h3F7

`define FDCR_OUTCTL_RESET 8'h00
`define FDCR_TAPE_RESET 2'h0
`define FDCR_OC_CODE_LSB 0
`define FDCR_OC_HRST_BIT 2
`define FDCR_OC_DMA_BIT 3
`define FDCR_OC_MOT_LSB 4

`define FDCR_TAPE_OE_NORMAL 8'h03
`define FDCR_OE_ALL 8'hFF
`define FDCR_OE_NONE 8'h00

`define FDCR_CLK_MHZ 40
`define FDCR_SRST_MIN_NS 100
`define FDCR_SRST_CYCLES \
  ((`FDCR_SRST_MIN_NS * `FDCR_CLK_MHZ + 999) / 1000)

`endif

/* verilog/fdcr_pkg.sv */
// Types shared by the drive control register bank.
// Assumes fdcr_cfg.svh is on the include path.
`default_nettype none
`include "fdcr_cfg.svh"

package fdcr_pkg;

  typedef enum logic [1:0] {
    FDCR_MODE_AT = 2'h0,
    FDCR_MODE_M30 = 2'h1,
    FDCR_MODE_PS2 = 2'h3
  } fdcr_mode_t;

  // Synchroniser lanes: 0 read data, 1 second drive, 3:2 media_ident_pins
  typedef struct packed {
    logic [7:0] drive_output_control;
    logic [1:0] tape_sel;
    logic wg_flag;
    logic rd_flag;
    logic wd_flag;
    logic rd_tog;
    logic wd_tog;
    logic wg_prev;
    logic wd_prev;
    logic [3:0] pin_s0;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_f;
    logic [2:0] srst_cnt;
    logic srst;
    logic [3:0] sel_n;
    logic [3:0] mot_n;
    logic [7:0] rdata;
    logic [7:0] rdata_oe;
  } fdcr_state_t;

endpackage : fdcr_pkg

`default_nettype wire

/* verilog/fdcr_regs.sv */
// Drive control register bank: output control, tape/media and
// second status registers with drive select and motor decode.
// Assumes host strobes on clk; disk pins arrive asynchronously.
`default_nettype none
`include "fdcr_cfg.svh"

module fdcr_regs
  import fdcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire fdcr_mode_t mode,
  input wire logic enhanced2,
  input wire logic two_drive,
  input wire logic swap_drives,
  input wire logic [7:0] cfg_f1,
  input wire logic [7:0] cfg_f2,
  input wire logic [`FDCR_ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic [7:0] host_rdata_oe,
  input wire logic write_gate,
  input wire logic write_data,
  input wire logic read_data_pin,
  input wire logic second_drive_present_n,
  input wire logic [1:0] media_ident_pins,
  output logic [3:0] select_out_n,
  output logic [3:0] motor_out_n,
  output logic soft_reset,
  output logic drq_oe,
  output logic irq_oe,
  output logic dack_tc_enable
);

  localparam logic [2:0] SRST_CYC = 3'(`FDCR_SRST_CYCLES);
  localparam int HB = `FDCR_OC_HRST_BIT;
  localparam int DB = `FDCR_OC_DMA_BIT;
  localparam int ML = `FDCR_OC_MOT_LSB;
  localparam int CL = `FDCR_OC_CODE_LSB;

  localparam fdcr_state_t ST_RST = '{
    drive_output_control: `FDCR_OUTCTL_RESET,
    tape_sel: `FDCR_TAPE_RESET,
    pin_s0: 4'h3,
    pin_s1: 4'h3,
    pin_s2: 4'h3,
    pin_f: 4'h3,
    srst: 1'b1,
    sel_n: 4'hF,
    mot_n: 4'hF,
    default: '0
  };

  fdcr_state_t st_reg;
  fdcr_state_t st_next;

  logic wr_oc;
  logic wr_tape;
  logic rd_dir;
  logic wg_rise;
  logic wd_fall;
  logic rd_fall;
  logic alt_mode;
  logic [3:0] agree;
  logic [1:0] code;
  logic [3:0] mot;
  logic [1:0] media;
  logic [1:0] drv_type;

  assign wr_oc = host_wr && (host_addr == `FDCR_OFS_OUTCTL);
  assign wr_tape = host_wr && (host_addr == `FDCR_OFS_TAPE);
  assign rd_dir = host_rd && (host_addr == `FDCR_OFS_DIGIN);
  assign alt_mode = (mode == FDCR_MODE_M30);

  always_comb begin
    st_next = st_reg;

    // Three-stage synchroniser; a change counts when 2 and 3 agree
    st_next.pin_s0 = {media_ident_pins, second_drive_present_n,
                      read_data_pin};
    st_next.pin_s1 = st_reg.pin_s0;
    st_next.pin_s2 = st_reg.pin_s1;
    agree = ~(st_reg.pin_s1 ^ st_reg.pin_s2);
    st_next.pin_f = (st_reg.pin_s1 & agree) | (st_reg.pin_f & ~agree);

    wg_rise = write_gate && !st_reg.wg_prev;
    wd_fall = st_reg.wd_prev && !write_data;
    rd_fall = st_reg.pin_f[0] && !st_next.pin_f[0];
    st_next.wg_prev = write_gate;
    st_next.wd_prev = write_data;

    // Set beats a clear landing in the same cycle
    st_next.wg_flag = (alt_mode && wg_rise)
                      || (st_reg.wg_flag && !rd_dir);
    st_next.rd_flag = (alt_mode && rd_fall)
                      || (st_reg.rd_flag && !rd_dir);
    st_next.wd_flag = wd_fall
                      || (st_reg.wd_flag && !rd_dir);
    st_next.rd_tog = st_reg.rd_tog ^ rd_fall;
    st_next.wd_tog = st_reg.wd_tog ^ wd_fall;

    // Writes accepted even while soft reset is held
    if (wr_oc) begin
      st_next.drive_output_control = host_wdata;
    end
    // Stored only for software; nothing inside looks at it
    if (wr_tape) begin
      st_next.tape_sel = host_wdata[1:0];
    end

    // Held bit low keeps the counter full, so a 0-then-1 pair of
    // writes still yields the full minimum width
    if (!st_next.drive_output_control[HB]) begin
      st_next.srst_cnt = SRST_CYC;
    end else if (st_reg.srst_cnt != 3'h0) begin
      st_next.srst_cnt = st_reg.srst_cnt - 3'h1;
    end
    // Only the output changes; registers here are untouched
    st_next.srst = !st_next.drive_output_control[HB]
                   || (st_next.srst_cnt != 3'h0);

    code = st_next.drive_output_control[CL +: 2];
    mot = st_next.drive_output_control[ML +: 4];
    if (!two_drive) begin
      for (int i = 0; i < 4; i++) begin
        st_next.sel_n[i] = (code != 2'(i));
      end
      st_next.mot_n = ~mot;
    end else if (!swap_drives) begin
      st_next.sel_n[0] = !(code == 2'h0 && mot[0]);
      st_next.sel_n[1] = !(code == 2'h1 && mot[1]);
      st_next.sel_n[3:2] = 2'h3;
      st_next.mot_n = ~mot;
    end else begin
      st_next.sel_n[1] = !(code == 2'h0 && mot[0]);
      st_next.sel_n[0] = !(code == 2'h1 && mot[1]);
      st_next.sel_n[3:2] = 2'h3;
      st_next.mot_n = {~mot[3:2], ~mot[0], ~mot[1]};
    end

    // Media pins are not reset, so these bits ride through resets
    media = st_reg.pin_f[3:2] ^ {cfg_f1[5], cfg_f1[4]};
    drv_type = cfg_f2[{st_reg.drive_output_control[CL +: 2], 1'b0} +: 2];

    // Read data valid for one cycle after the strobe
    st_next.rdata_oe = `FDCR_OE_NONE;
    if (host_rd) begin
      case (host_addr)
        `FDCR_OFS_OUTCTL: begin
          st_next.rdata = st_reg.drive_output_control;
          st_next.rdata_oe = `FDCR_OE_ALL;
        end
        `FDCR_OFS_TAPE: begin
          if (enhanced2) begin
            st_next.rdata = {media, drv_type, cfg_f1[7], cfg_f1[6],
                             st_reg.tape_sel};
            st_next.rdata_oe = `FDCR_OE_ALL;
          end else begin
            st_next.rdata = {6'h00, st_reg.tape_sel};
            st_next.rdata_oe = `FDCR_TAPE_OE_NORMAL;
          end
        end
        `FDCR_OFS_STATUS2: begin
          case (mode)
            FDCR_MODE_M30: begin
              st_next.rdata = {st_reg.pin_f[1],
                               st_reg.sel_n[1], st_reg.sel_n[0],
                               st_reg.wd_flag, st_reg.rd_flag,
                               st_reg.wg_flag,
                               st_reg.sel_n[3],
                               st_reg.sel_n[2]};
              st_next.rdata_oe = `FDCR_OE_ALL;
            end
            FDCR_MODE_PS2: begin
              st_next.rdata = {2'h3, st_reg.drive_output_control[CL],
                               st_reg.wd_tog, st_reg.rd_tog,
                               st_reg.wg_prev,
                               st_reg.drive_output_control[ML + 1], st_reg.drive_output_control[ML]};
              st_next.rdata_oe = `FDCR_OE_ALL;
            end
            default: begin
              st_next.rdata_oe = `FDCR_OE_NONE;
            end
          endcase
        end
        default: begin
          st_next.rdata_oe = `FDCR_OE_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= ST_RST;
      // Media lanes keep sampling so their read bits never reset
      st_reg.pin_s0[3:2] <= st_next.pin_s0[3:2];
      st_reg.pin_s1[3:2] <= st_next.pin_s1[3:2];
      st_reg.pin_s2[3:2] <= st_next.pin_s2[3:2];
      st_reg.pin_f[3:2] <= st_next.pin_f[3:2];
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata = st_reg.rdata;
  assign host_rdata_oe = st_reg.rdata_oe;
  assign select_out_n = st_reg.sel_n;
  assign motor_out_n = st_reg.mot_n;
  assign soft_reset = st_reg.srst;

  // Enhanced system mode ignores the enable bit, also in reset
  always_comb begin
    drq_oe = (mode == FDCR_MODE_PS2) || st_reg.drive_output_control[DB];
    irq_oe = drq_oe;
    dack_tc_enable = drq_oe;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_oc_write;
    wr_oc;
  endsequence

  chk_outctl_store: assert property (
    s_oc_write |=> st_reg.drive_output_control == $past(host_wdata))
    else $error("output control write not stored");

  chk_sel_onehot: assert property (
    (!two_drive && $past(!two_drive) && $past(reset_n))
      |-> $countones(~select_out_n) == 1)
    else $error("four-drive decode not one-hot");

  chk_srst_assert: assert property (
    (wr_oc && !host_wdata[HB]) |=> soft_reset)
    else $error("held reset write did not reset");

  chk_srst_width: assert property (
    $rose(soft_reset) |-> soft_reset [*4])
    else $error("soft reset shorter than 100 ns");

  chk_dma_compat: assert property (
    (mode != FDCR_MODE_PS2) |-> drq_oe == st_reg.drive_output_control[DB])
    else $error("DMA pin enable does not follow bit");

  chk_dma_enhanced: assert property (
    (mode == FDCR_MODE_PS2) |-> (drq_oe && irq_oe))
    else $error("DMA pins disabled in enhanced mode");

  chk_gate_flag: assert property (
    (alt_mode && $rose(write_gate) && $past(write_gate) == st_reg.wg_prev)
      |=> st_reg.wg_flag)
    else $error("write gate flag not set");

  sequence s_dir_read_quiet;
    rd_dir && !wd_fall;
  endsequence

  chk_wd_clear: assert property (
    s_dir_read_quiet |=> !st_reg.wd_flag)
    else $error("write data flag not cleared");

  chk_tape_normal: assert property (
    (host_rd && host_addr == `FDCR_OFS_TAPE && !enhanced2)
      |=> host_rdata_oe == `FDCR_TAPE_OE_NORMAL)
    else $error("normal tape read drives upper bits");

  chk_swap_sel: assert property (
    (two_drive && swap_drives && st_next.drive_output_control[1:0] == 2'h0
      && st_next.drive_output_control[ML]) |=> !select_out_n[1] && select_out_n[0])
    else $error("swapped decode wrong for code 00");

  chk_wd_set: assert property (
    wd_fall |=> st_reg.wd_flag)
    else $error("write data flag not set");

  chk_rd_set: assert property (
    (alt_mode && rd_fall) |=> st_reg.rd_flag)
    else $error("read data flag not set");

  chk_wg_clear: assert property (
    (rd_dir && !(alt_mode && wg_rise)) |=> !st_reg.wg_flag)
    else $error("write gate flag not cleared");

  // In four-drive mode motor lines must follow the stored bits in the same cycle they are stored
  chk_motor_four: assert property (
    !two_drive |=> motor_out_n == ~$past(st_next.drive_output_control[7:4]))
    else $error("motor outputs do not follow bits");

  chk_tape_hold: assert property (
    !wr_tape |=> st_reg.tape_sel == $past(st_reg.tape_sel))
    else $error("tape select changed without a write");

  chk_drive_pin: assert property (
    (host_rd && host_addr == `FDCR_OFS_STATUS2 && alt_mode)
      |=> host_rdata[7] == $past(st_reg.pin_f[1]))
    else $error("second drive bit wrong");

  sequence s_tape_rd_enh;
    host_rd && host_addr == `FDCR_OFS_TAPE && enhanced2;
  endsequence

  chk_media_bits: assert property (
    s_tape_rd_enh
      |=> host_rdata[7:6] == $past(st_reg.pin_f[3:2] ^ cfg_f1[5:4]))
    else $error("media bits wrong");

  chk_boot_drive: assert property (
    s_tape_rd_enh |=> host_rdata[3:2] == $past(cfg_f1[7:6]))
    else $error("boot drive bits wrong");

endmodule : fdcr_regs

`default_nettype wire

/* tb/fdcr_drive_model.sv */
// Floppy drive stand-in on the disk interface pins.
// Assumes the bench shares clk; pins change only after clk edges.
`default_nettype none

module fdcr_drive_model #(
  parameter logic [1:0] MEDIA = 2'h2
) (
  input wire logic clk,
  input wire logic [3:0] select_out_n,
  input wire logic [3:0] motor_out_n,
  output logic read_data_pin,
  output logic second_drive_present_n,
  output logic [1:0] media_ident_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  logic spin;

  // Flux only from a drive that is both selected and spinning
  assign spin = |(~select_out_n & ~motor_out_n);
  assign second_drive_present_n = 1'b0;
  assign media_ident_pins = MEDIA;
  initial read_data_pin = 1'b1;

  // Idle read line rests at its pull-up level
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    read_data_pin <= spin ? phase[1] : 1'b1;
  end
endmodule : fdcr_drive_model

`default_nettype wire

/* tb/fdcr_regs_bench.sv */
// Self-checking bench for the drive control register bank.
// Assumes fdcr_pkg and the drive model are compiled first.
`default_nettype none

module fdcr_regs_bench;
  import fdcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, enhanced2 = 1'b0, two_drive = 1'b0;
  logic swap_drives = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic write_gate = 1'b0, write_data = 1'b1, soft_reset;
  logic drq_oe, irq_oe, dack_tc_enable, read_data_pin, drv2_n;
  logic [7:0] cfg_f1 = 8'h90, cfg_f2 = 8'hE4, host_wdata = 8'h00;
  logic [7:0] host_rdata, host_rdata_oe;
  logic [9:0] host_addr = 10'h000;
  logic [3:0] select_out_n, motor_out_n, s;
  logic [1:0] media;
  fdcr_mode_t mode = FDCR_MODE_AT;
  int err_count = 0, n_compared = 0, n;
  logic [7:0] act[4] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F};
  logic [7:0] two[5] = '{8'h1C, 8'h2D, 8'h0C, 8'h2C, 8'h3D};

  always #12.5 clk = ~clk;

  fdcr_regs i_fdcr_regs (.clk(clk), .reset_n(reset_n), .mode(mode),
    .enhanced2(enhanced2), .two_drive(two_drive), .swap_drives(swap_drives),
    .cfg_f1(cfg_f1), .cfg_f2(cfg_f2), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .write_gate(write_gate), .write_data(write_data),
    .read_data_pin(read_data_pin), .second_drive_present_n(drv2_n),
    .media_ident_pins(media), .select_out_n(select_out_n),
    .motor_out_n(motor_out_n), .soft_reset(soft_reset), .drq_oe(drq_oe),
    .irq_oe(irq_oe), .dack_tc_enable(dack_tc_enable));

  fdcr_drive_model i_fdcr_drive_model (.clk(clk),
    .select_out_n(select_out_n), .motor_out_n(motor_out_n),
    .read_data_pin(read_data_pin), .second_drive_present_n(drv2_n),
    .media_ident_pins(media));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask : wr

  // Answer lands on the same edge that samples the strobe
  task automatic rd(input logic [9:0] a, input logic [7:0] exp,
                    input logic [7:0] eoe, input logic [7:0] msk = 8'hFF);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    chk(host_rdata_oe, eoe);
    chk(host_rdata & eoe & msk, exp);
  endtask : rd

  task automatic hw_reset(input fdcr_mode_t m);
    @(posedge clk);
    reset_n <= 1'b0;
    mode <= m;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, drq_oe}, {7'h0, m == FDCR_MODE_PS2});
    chk({7'h0, soft_reset}, 8'h01);
    chk({select_out_n, motor_out_n}, 8'hFF);
    @(posedge clk);
    reset_n <= 1'b1;
  endtask : hw_reset

  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  initial begin
    hw_reset(FDCR_MODE_AT);
    rd(10'h3F2, 8'h00, 8'hFF);
    rd(10'h3F0, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(10'h3F2, act[i]);
      repeat (6) @(posedge clk);
      #1;
      chk({select_out_n, motor_out_n}, ~{4'h1 << i, 4'h1 << i});
      chk({5'h0, drq_oe, irq_oe, dack_tc_enable}, 8'h07);
      chk({7'h0, soft_reset}, 8'h00);
      rd(10'h3F2, act[i], 8'hFF);
    end
    wr(10'h3F3, 8'hFF);
    rd(10'h3F3, 8'h03, 8'h03);
    // Clear then set the held bit on consecutive edges
    @(posedge clk);
    host_addr <= 10'h3F2;
    host_wdata <= 8'h8B;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wdata <= 8'h8F;
    #1;
    n = (soft_reset === 1'b1);
    @(posedge clk);
    host_wr <= 1'b0;
    #1;
    repeat (8) begin
      n += (soft_reset === 1'b1);
      @(posedge clk);
      #1;
    end
    chk({7'h0, n >= 4}, 8'h01);
    chk({7'h0, soft_reset}, 8'h00);
    rd(10'h3F2, 8'h8F, 8'hFF);
    rd(10'h3F3, 8'h03, 8'h03);
    two_drive <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      swap_drives <= w[0];
      foreach (two[k]) begin
        wr(10'h3F2, two[k]);
        repeat (3) @(posedge clk);
        #1;
        s[0] = two[k][1:0] == 2'h0 && two[k][4];
        s[1] = two[k][1:0] == 2'h1 && two[k][5];
        if (w == 1) s[1:0] = {s[0], s[1]};
        chk({select_out_n, motor_out_n[1:0]}, {2'h3, ~s[1:0],
            w == 1 ? {~two[k][4], ~two[k][5]}
                   : ~two[k][5:4]});
      end
    end
    two_drive <= 1'b0;
    enhanced2 <= 1'b1;
    wr(10'h3F3, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(10'h3F2, 8'h0C | 8'(c));
      rd(10'h3F3, {2'h3, 2'(c), 2'h2, 2'h1}, 8'hFF);
    end
    enhanced2 <= 1'b0;
    hw_reset(FDCR_MODE_M30);
    wr(10'h3F2, 8'h1C);
    @(posedge clk);
    write_gate <= 1'b1;
    write_data <= 1'b0;
    repeat (8) @(posedge clk);
    rd(10'h3F1, 8'h5F, 8'hFF);
    wr(10'h3F2, 8'h04);
    repeat (8) @(posedge clk);
    rd(10'h3F7, 8'h00, 8'h00);
    rd(10'h3F1, 8'h43, 8'hFF);
    write_gate <= 1'b0;
    hw_reset(FDCR_MODE_PS2);
    rd(10'h3F2, 8'h00, 8'hFF);
    wr(10'h3F2, 8'h21);
    rd(10'h3F1, 8'hE2, 8'hFF, 8'hF7);
    wr(10'h3F2, 8'h01);
    rd(10'h3F1, 8'hE0, 8'hFF, 8'hF7);
    chk({6'h0, drq_oe, irq_oe}, 8'h03);
    stop_test();
  end
endmodule : fdcr_regs_bench

`default_nettype wire
